// [bench/dus_stack_model.sv]
// Stack engine model: answers each readout start with a span of VME activity
`timescale 1ns/1ps
module dus_stack_model #(
    parameter int LAT = 3,
    parameter int SPAN = 6
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Start in, outstanding operations out
    input wire logic STACK_START,
    output logic STACK_BUSY,
    output int starts
);
    // Cycles left until the span ends
    int left;
    // Latency first, then busy; a larger LAT makes a slow engine
    always @(posedge MCLK) begin
        if (RST) begin
            left <= 0;
            starts <= 0;
            STACK_BUSY <= 1'b0;
        end else if (STACK_START) begin
            left <= LAT + SPAN;
            starts <= starts + 1;
        end else if (left > 0) begin
            left <= left - 1;
            STACK_BUSY <= left > 1 && left <= SPAN + 1;
        end
    end
endmodule

// [bench/dus_user_io_chk.sv]
// Assertion checker for the user I/O block
`timescale 1ns/1ps
`include "dus_defs.svh"
module dus_user_io_chk
    import dus_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYC = 20
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_RVALID,
    input wire logic ACTION_WR,
    // Acquisition status and control
    input wire logic ACQUIRE,
    input wire logic STACK_BUSY,
    input wire logic RUN_CLOSE,
    input wire logic SCALER_STACK_VALID,
    input wire logic STACK_START,
    input wire logic SCALER_STACK_START,
    input wire logic BUSY,
    input wire logic USB_TRIGGER
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Shadow of the scaler limits, so a periodic run can be told from a closing run
    logic [23:0] lim;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lim <= 24'h0;
        end else if (REG_WR && REG_ADDR == `DUS_OFF_ACQ) begin
            lim <= REG_WDATA[31:8];
        end
    end
    property p_usb; ACTION_WR && REG_WDATA[1] |=> USB_TRIGGER; endproperty
    a_usb: assert property (p_usb) else $error("usb trigger missing");
    property p_usb_cause; USB_TRIGGER |-> $past(ACTION_WR && REG_WDATA[1]); endproperty
    a_usb_cause: assert property (p_usb_cause) else $error("usb trigger without write");
    property p_rd; REG_RD |=> REG_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read answer missing");
    property p_rd_cause; REG_RVALID |-> $past(REG_RD); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
    property p_busy_set; $rose(BUSY) && !$past(RST) |-> $past(ACQUIRE); endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy outside acquisition");
    property p_busy_drop; $fell(BUSY) && !$past(RST) |-> !$past(STACK_BUSY); endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy dropped early");
    property p_busy_hold; BUSY && STACK_BUSY |=> BUSY; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy lost");
    property p_start; STACK_START |-> BUSY ##1 !STACK_START; endproperty
    a_start: assert property (p_start) else $error("bad stack start");
    property p_close; RUN_CLOSE && SCALER_STACK_VALID |=> SCALER_STACK_START; endproperty
    a_close: assert property (p_close) else $error("no scaler run at close");
    property p_quiet;
        SCALER_STACK_START |-> $past(RUN_CLOSE && SCALER_STACK_VALID) || $past(lim) != 24'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("scaler run with zero limits");
endmodule
bind dus_user_io dus_user_io_chk #(.HALF_SEC_CYC(HALF_SEC_CYC)) i_dus_user_io_chk (
    .MCLK(MCLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID), .ACTION_WR(ACTION_WR),
    .ACQUIRE(ACQUIRE), .STACK_BUSY(STACK_BUSY), .RUN_CLOSE(RUN_CLOSE),
    .SCALER_STACK_VALID(SCALER_STACK_VALID), .STACK_START(STACK_START),
    .SCALER_STACK_START(SCALER_STACK_START), .BUSY(BUSY), .USB_TRIGGER(USB_TRIGGER));

// [bench/test_dus_user_io.sv]
// Self-checking testbench for the user I/O block
`timescale 1ns/1ps
`include "dus_defs.svh"
module test_dus_user_io;
    // ************************************************************
    // Signals, design and stack engine model
    // ************************************************************
    logic MCLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, ACTION_WR = 1'b0;
    logic NIM_INPUT_ONE = 1'b0, NIM_INPUT_TWO = 1'b0, VME_DTACK = 1'b0, VME_BERR = 1'b0;
    logic VME_BUS_REQ = 1'b0, VME_BUS_GRANT = 1'b0, VME_AS = 1'b0, ACQUIRE = 1'b0;
    logic IRQ_EVENT = 1'b0, EVENT_END = 1'b0, RUN_CLOSE = 1'b0, SCALER_STACK_VALID = 1'b0;
    logic VME_CMD_EXEC = 1'b0, XFER_EVENT = 1'b0, XFER_BUFFER = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
    logic [15:0] LED_STATUS = 16'h0;
    logic REG_RVALID, STACK_START, SCALER_STACK_START, BUSY, USB_TRIGGER, STACK_BUSY;
    logic NIM_OUTPUT_ONE, NIM_OUTPUT_TWO;
    logic [3:0] LED;
    int fail_count = 0, checked = 0, starts, n, k;
    logic [7:0] rw [6] = '{`DUS_OFF_ACQ, `DUS_OFF_LED, `DUS_OFF_DEV, `DUS_OFF_PG1,
        `DUS_OFF_PG2, `DUS_OFF_EXT};
    // 200 MHz clock
    always #2.5 MCLK = ~MCLK;
    dus_user_io #(.HALF_SEC_CYC(20)) i_dus_user_io (.MCLK(MCLK), .RST(RST),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .ACTION_WR(ACTION_WR),
        .NIM_INPUT_ONE(NIM_INPUT_ONE), .NIM_INPUT_TWO(NIM_INPUT_TWO), .VME_AS(VME_AS),
        .VME_DTACK(VME_DTACK), .VME_BERR(VME_BERR), .VME_BUS_REQ(VME_BUS_REQ),
        .VME_BUS_GRANT(VME_BUS_GRANT), .ACQUIRE(ACQUIRE), .IRQ_EVENT(IRQ_EVENT),
        .STACK_BUSY(STACK_BUSY), .EVENT_END(EVENT_END), .RUN_CLOSE(RUN_CLOSE),
        .SCALER_STACK_VALID(SCALER_STACK_VALID), .VME_CMD_EXEC(VME_CMD_EXEC),
        .XFER_EVENT(XFER_EVENT), .XFER_BUFFER(XFER_BUFFER), .LED_STATUS(LED_STATUS),
        .STACK_START(STACK_START), .SCALER_STACK_START(SCALER_STACK_START), .BUSY(BUSY),
        .USB_TRIGGER(USB_TRIGGER), .LED(LED), .NIM_OUTPUT_ONE(NIM_OUTPUT_ONE),
        .NIM_OUTPUT_TWO(NIM_OUTPUT_TWO));
    dus_stack_model i_dus_stack_model (.MCLK(MCLK), .RST(RST), .STACK_START(STACK_START),
        .STACK_BUSY(STACK_BUSY), .starts(starts));
    // Inputs change only at the falling edge
    task automatic tick(input int c);
        repeat (c) @(negedge MCLK);
    endtask
    task automatic summarize;
        $display("fail_count=%0d checked=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic lost;
        fail_count++;
        summarize();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe; the spare cycle keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = v;
        tick(1);
        REG_WR = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int i;
        REG_RD = 1'b1;
        REG_ADDR = a;
        tick(1);
        REG_RD = 1'b0;
        for (i = 0; i < 4 && REG_RVALID !== 1'b1; i++) tick(1);
        if (i == 4) lost();
        v = REG_RDATA;
        tick(1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] v);
        rd(a, d);
        chk(d, v);
    endtask
    // Sends e spaced events and counts scaler starts over e*2+w cycles
    task automatic evw(input int e, input int w, output int h);
        h = 0;
        for (int j = 0; j < 2 * e + w; j++) begin
            EVENT_END = j < 2 * e && j % 2 == 0;
            tick(1);
            if (SCALER_STACK_START === 1'b1) h++;
        end
        EVENT_END = 1'b0;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(5);
        RST = 1'b0;
        tick(1);
        foreach (rw[i]) rchk(rw[i], `DUS_RST_WORD);
        rchk(8'h04, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(rw[i], 32'h3A46_6A17 ^ (32'h0101 * i));
            rchk(rw[i], 32'h3A46_6A17 ^ (32'h0101 * i));
        end
        wr(`DUS_OFF_CNT1, 32'hFFFF_FFFF);
        rchk(`DUS_OFF_CNT1, 32'h0);
        wr(`DUS_OFF_DEV, 32'h8F33_0FFF);
        rchk(`DUS_OFF_DEV, (32'h3A46_6A17 ^ 32'h0202) & ~32'h0044_0000);
        // Action write: bit 1 set, then clear
        wr(`DUS_OFF_DEV, 32'h0000_0007);
        REG_WDATA = 32'h2;
        ACTION_WR = 1'b1;
        tick(1);
        ACTION_WR = 1'b0;
        chk({31'h0, USB_TRIGGER}, 32'h1);
        k = 0;
        repeat (6) begin
            tick(1);
            k += NIM_OUTPUT_ONE;
        end
        chk({31'h0, k > 0}, 32'h1);
        REG_WDATA = 32'h1;
        ACTION_WR = 1'b1;
        tick(1);
        ACTION_WR = 1'b0;
        chk({31'h0, USB_TRIGGER}, 32'h0);
        wr(`DUS_OFF_DEV, 32'h0000_000F);
        tick(6);
        chk({31'h0, NIM_OUTPUT_ONE}, 32'h1);
        wr(`DUS_OFF_DEV, 32'h0000_0200);
        VME_AS = 1'b1;
        tick(8);
        chk({31'h0, NIM_OUTPUT_TWO}, 32'h1);
        VME_AS = 1'b0;
        // Readout trigger with a two microsecond delay; a second trigger is refused
        wr(`DUS_OFF_DEV, 32'h0);
        wr(`DUS_OFF_ACQ, 32'h2);
        ACQUIRE = 1'b1;
        IRQ_EVENT = 1'b1;
        for (n = 1; n < 1000; n++) begin
            tick(1);
            IRQ_EVENT = n == 50;
            if (n == 1) chk({31'h0, BUSY}, 32'h1);
            if (n == 100) chk({31'h0, NIM_OUTPUT_ONE}, 32'h1);
            if (STACK_START === 1'b1) break;
        end
        if (n == 1000) lost();
        chk(n, `DUS_US_CYC * 2 + 2);
        for (n = 0; n < 40 && BUSY !== 1'b0; n++) tick(1);
        if (n == 40) lost();
        chk(starts, 32'h1);
        // Scaler by event count, then timer, then both zero
        wr(`DUS_OFF_ACQ, 32'h0003_0000);
        evw(2, 6, k);
        chk(k, 32'h0);
        evw(1, 6, k);
        chk(k, 32'h1);
        evw(2, 6, k);
        chk(k, 32'h0);
        wr(`DUS_OFF_ACQ, 32'h0000_0100);
        evw(0, 25, k);
        evw(0, 100, k);
        chk({31'h0, k >= 4 && k <= 5}, 32'h1);
        wr(`DUS_OFF_ACQ, 32'h0);
        tick(4);
        evw(3, 100, k);
        chk(k, 32'h0);
        ACQUIRE = 1'b0;
        SCALER_STACK_VALID = 1'b1;
        RUN_CLOSE = 1'b1;
        tick(1);
        RUN_CLOSE = 1'b0;
        chk({31'h0, SCALER_STACK_START}, 32'h1);
        // Counter one on the first NIM input, then its reset bit
        wr(`DUS_OFF_DEV, 32'h0005_0000);
        repeat (5) begin
            NIM_INPUT_ONE = 1'b1;
            tick(4);
            NIM_INPUT_ONE = 1'b0;
            tick(4);
        end
        rchk(`DUS_OFF_CNT1, 32'h5);
        wr(`DUS_OFF_DEV, 32'h0008_0000);
        rchk(`DUS_OFF_CNT1, 32'h0);
        rchk(`DUS_OFF_DEV, 32'h0005_0000);
        // Free-running pulser: delay 3 and gate 2 ticks, counted by counter one
        wr(`DUS_OFF_EXT, 32'h0);
        wr(`DUS_OFF_PG1, 32'h0002_0003);
        wr(`DUS_OFF_DEV, 32'h0604_0004);
        tick(250);
        rd(`DUS_OFF_CNT1, d);
        chk({31'h0, d >= 18 && d <= 21}, 32'h1);
        // Indicators on the bus acknowledge, one inverted, then latched
        wr(`DUS_OFF_LED, 32'h0C04_0404);
        VME_DTACK = 1'b1;
        tick(8);
        chk({28'h0, LED}, 32'h7);
        VME_DTACK = 1'b0;
        tick(8);
        chk({28'h0, LED}, 32'h8);
        wr(`DUS_OFF_LED, 32'h0C04_0414);
        VME_DTACK = 1'b1;
        tick(4);
        VME_DTACK = 1'b0;
        tick(8);
        chk({28'h0, LED}, 32'h9);
        wr(`DUS_OFF_LED, 32'h0C04_0404);
        wr(`DUS_OFF_LED, 32'h0C04_0414);
        tick(8);
        chk({28'h0, LED}, 32'h8);
        summarize();
    end
endmodule

// [common/dus_defs.svh]
// Offsets, field positions, reset values and timing counts of the user I/O block
`ifndef DUS_DEFS_SVH
`define DUS_DEFS_SVH

// ************************************************************
// Register offsets (byte offsets of the internal register file)
// ************************************************************
`define DUS_OFF_ACQ 8'h08
`define DUS_OFF_LED 8'h0C
`define DUS_OFF_DEV 8'h10
`define DUS_OFF_PG1 8'h14
`define DUS_OFF_PG2 8'h18
`define DUS_OFF_CNT1 8'h1C
`define DUS_OFF_CNT2 8'h20
`define DUS_OFF_EXT 8'h38

// ************************************************************
// Reset values
// ************************************************************
`define DUS_RST_WORD 32'h0000_0000

// ************************************************************
// Field positions
// ************************************************************
`define DUS_ACQ_DLY_LSB 0
`define DUS_ACQ_PER_LSB 8
`define DUS_ACQ_FRQ_LSB 16
`define DUS_SEL_INV 3
`define DUS_SEL_LAT 4
`define DUS_DEV_CCODE_LSB 16
`define DUS_DEV_CEN 18
`define DUS_DEV_CRST 19
`define DUS_DEV_GCODE_LSB 24
`define DUS_DEV_FRZ 31
`define DUS_PG_GATE_LSB 16
`define DUS_ACT_USB_TRIG 1

// ************************************************************
// Timing
// ************************************************************
`define DUS_MCLK_PS 5000
`define DUS_US_PS 1000000
`define DUS_US_CYC ((`DUS_US_PS + `DUS_MCLK_PS - 1) / `DUS_MCLK_PS)
`define DUS_HALF_SEC_MS 500
`define DUS_HALF_SEC_CYC (`DUS_HALF_SEC_MS * (1000000000 / `DUS_MCLK_PS))
// 12.5 ns tick from a 5 ns clock: two ticks every five clocks
`define DUS_TICK_STEP 3'h2
`define DUS_TICK_MOD 3'h5

`endif

// [common/dus_pkg.sv]
// Types shared by the user I/O block
package dus_pkg;

    // Delay and gate generator states
    typedef enum logic [1:0] {
        DUS_PG_IDLE,
        DUS_PG_DELAY,
        DUS_PG_GATE
    } dus_pg_st_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] acq;
        logic [31:0] led_sel;
        logic [31:0] dev_sel;
        logic [31:0] pg1;
        logic [31:0] pg2;
        logic [31:0] ext;
        logic [1:0][31:0] cnt;
        logic [31:0] rdata;
        logic rvalid;
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] pin_d;
        logic [7:0] us_cnt;
        logic [7:0] dly_cnt;
        logic dly_on;
        logic busy;
        logic stk_seen;
        logic stack_start;
        logic [26:0] half_sub;
        logic [7:0] halves;
        logic [15:0] ev_cnt;
        logic sc_start;
        logic usb_trig;
        logic [2:0] phase;
        logic tick;
        dus_pg_st_t [1:0] pg_st;
        logic [1:0][31:0] pg_cnt;
        logic [1:0] pg_sd;
        logic [1:0] cnt_sd;
        logic [5:0] held;
        logic [5:0] acc;
        logic [5:0] lout;
    } dus_state_t;

endpackage

// [logic/dus_user_io.sv]
// User I/O, trigger delay, scaler scheduling, counters and pulse generators
`timescale 1ns/1ps
`include "dus_defs.svh"

module dus_user_io
    import dus_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYC = `DUS_HALF_SEC_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Internal register command port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic ACTION_WR,
    // Front panel and bus pins, asynchronous
    input wire logic NIM_INPUT_ONE,
    input wire logic NIM_INPUT_TWO,
    input wire logic VME_DTACK,
    input wire logic VME_BERR,
    input wire logic VME_BUS_REQ,
    input wire logic VME_BUS_GRANT,
    input wire logic VME_AS,
    // Acquisition status from the stack engine, same clock
    input wire logic ACQUIRE,
    input wire logic IRQ_EVENT,
    input wire logic STACK_BUSY,
    input wire logic EVENT_END,
    input wire logic RUN_CLOSE,
    input wire logic SCALER_STACK_VALID,
    input wire logic VME_CMD_EXEC,
    input wire logic XFER_EVENT,
    input wire logic XFER_BUFFER,
    input wire logic [15:0] LED_STATUS,
    // Acquisition control out
    output logic STACK_START,
    output logic SCALER_STACK_START,
    output logic BUSY,
    output logic USB_TRIGGER,
    // Indicators and NIM outputs
    output logic [3:0] LED,
    output logic NIM_OUTPUT_ONE,
    output logic NIM_OUTPUT_TWO
);

    // ************************************************************
    // State registers
    // ************************************************************
    dus_state_t r; // Current state
    dus_state_t next_r; // Next state

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // All behaviour lives in one process so every field has one driver
    always_comb begin
        logic [6:0] rise; // Rising edges of synchronised pins
        logic trig; // Readout start request
        logic fire; // Scaler stack request
        logic [2:0] gcode; // Generator input code
        logic gsrc; // Generator input level
        logic gedge; // Generator input edge
        logic pulser; // Generator runs free
        logic [31:0] dly; // Generator total delay in ticks
        logic [1:0] ccode; // Counter input code
        logic csrc; // Counter input level
        logic [4:0] sel; // Output selector, low 5 bits of its byte
        logic [3:0] spec; // Output-specific sources
        logic [3:0] shr; // Shared sources
        logic v; // Selected and inverted source
        logic sig; // Output level before tick alignment
        rise = '0;
        trig = 1'b0;
        fire = 1'b0;
        gcode = '0;
        gsrc = 1'b0;
        gedge = 1'b0;
        pulser = 1'b0;
        dly = '0;
        ccode = '0;
        csrc = 1'b0;
        sel = '0;
        spec = '0;
        shr = '0;
        v = 1'b0;
        sig = 1'b0;
        next_r = r;

        // Pulses last one clock by default
        next_r.rvalid = 1'b0;
        next_r.stack_start = 1'b0;
        next_r.sc_start = 1'b0;
        next_r.usb_trig = 1'b0;

        // Two-stage synchronisers; only the second stage is read
        next_r.s1 = {VME_AS, VME_BUS_GRANT, VME_BUS_REQ, VME_BERR, VME_DTACK,
            NIM_INPUT_TWO, NIM_INPUT_ONE};
        next_r.s2 = r.s1;
        next_r.pin_d = r.s2;
        rise = r.s2 & ~r.pin_d;

        // 80 MHz tick from the 200 MHz clock by phase accumulation
        next_r.tick = 1'b0;
        next_r.phase = 3'(r.phase + `DUS_TICK_STEP);
        if (next_r.phase >= `DUS_TICK_MOD) begin
            next_r.phase = 3'(next_r.phase - `DUS_TICK_MOD);
            next_r.tick = 1'b1;
        end

        // USB trigger on an action write with bit 1 set
        if (ACTION_WR && REG_WDATA[`DUS_ACT_USB_TRIG]) begin
            next_r.usb_trig = 1'b1;
        end

        // Readout trigger delay; a new start is ignored while busy
        trig = ACQUIRE && (rise[0] || IRQ_EVENT);
        if (trig && !r.busy) begin
            next_r.dly_on = 1'b1;
            next_r.dly_cnt = r.acq[`DUS_ACQ_DLY_LSB +: 8];
            next_r.us_cnt = '0;
            next_r.busy = 1'b1;
            next_r.stk_seen = 1'b0;
        end else if (r.dly_on) begin
            if (r.dly_cnt == 8'h00) begin
                next_r.dly_on = 1'b0;
                next_r.stack_start = 1'b1;
            end else if (r.us_cnt == 8'(`DUS_US_CYC - 1)) begin
                next_r.us_cnt = '0;
                next_r.dly_cnt = 8'(r.dly_cnt - 8'h01);
            end else begin
                next_r.us_cnt = 8'(r.us_cnt + 8'h01);
            end
        end else if (r.busy) begin
            // Busy drops as soon as the stack's bus cycles are done
            if (STACK_BUSY) begin
                next_r.stk_seen = 1'b1;
            end else if (r.stk_seen) begin
                next_r.busy = 1'b0;
            end
        end

        // Scaler schedule: timer and event count, first one wins
        if (ACQUIRE) begin
            if (r.half_sub == 27'(HALF_SEC_CYC - 1)) begin
                next_r.half_sub = '0;
                if (r.halves != 8'hFF) begin
                    next_r.halves = 8'(r.halves + 8'h01);
                end
            end else begin
                next_r.half_sub = 27'(r.half_sub + 27'h1);
            end
            if (EVENT_END && r.ev_cnt != 16'hFFFF) begin
                next_r.ev_cnt = 16'(r.ev_cnt + 16'h0001);
            end
        end
        // A zero field never fires, so both zero means no periodic run
        fire = ACQUIRE && (
            (r.acq[`DUS_ACQ_PER_LSB +: 8] != 8'h00 &&
                r.halves >= r.acq[`DUS_ACQ_PER_LSB +: 8]) ||
            (r.acq[`DUS_ACQ_FRQ_LSB +: 16] != 16'h0000 &&
                r.ev_cnt >= r.acq[`DUS_ACQ_FRQ_LSB +: 16]));
        if (RUN_CLOSE && SCALER_STACK_VALID) begin
            fire = 1'b1;
        end
        if (fire) begin
            next_r.sc_start = 1'b1;
            next_r.half_sub = '0;
            next_r.halves = '0;
            next_r.ev_cnt = '0;
        end

        // Delay and gate generators, counted in 12.5 ns ticks
        for (int i = 0; i < 2; i++) begin
            gcode = r.dev_sel[`DUS_DEV_GCODE_LSB + 4 * i +: 3];
            case (gcode)
                3'h1: gsrc = r.s2[0];
                3'h2: gsrc = r.s2[1];
                3'h3: gsrc = r.stack_start;
                3'h4: gsrc = EVENT_END;
                3'h5: gsrc = r.usb_trig;
                default: gsrc = 1'b0; // Code 0 and 7 have no input
            endcase
            next_r.pg_sd[i] = gsrc;
            gedge = gsrc && !r.pg_sd[i];
            pulser = (gcode == 3'h6);
            // Each coarse count is 65536 fine ticks, 819.2 us
            dly = (i == 0) ? {r.ext[15:0], r.pg1[15:0]} :
                {r.ext[31:16], r.pg2[15:0]};
            unique case (r.pg_st[i])
                DUS_PG_IDLE: begin
                    if (gedge || pulser) begin
                        next_r.pg_st[i] = DUS_PG_DELAY;
                        next_r.pg_cnt[i] = dly;
                    end
                end
                DUS_PG_DELAY: begin
                    if (r.tick) begin
                        if (r.pg_cnt[i] <= 32'h1) begin
                            next_r.pg_st[i] = DUS_PG_GATE;
                            next_r.pg_cnt[i] = (i == 0) ?
                                {16'h0000, r.pg1[`DUS_PG_GATE_LSB +: 16]} :
                                {16'h0000, r.pg2[`DUS_PG_GATE_LSB +: 16]};
                        end else begin
                            next_r.pg_cnt[i] = 32'(r.pg_cnt[i] - 32'h1);
                        end
                    end
                end
                DUS_PG_GATE: begin
                    if (r.tick) begin
                        if (r.pg_cnt[i] <= 32'h1) begin
                            // Pulser goes straight back into delay
                            next_r.pg_st[i] = pulser ? DUS_PG_DELAY : DUS_PG_IDLE;
                            next_r.pg_cnt[i] = dly;
                        end else begin
                            next_r.pg_cnt[i] = 32'(r.pg_cnt[i] - 32'h1);
                        end
                    end
                end
                default: next_r.pg_st[i] = DUS_PG_IDLE;
            endcase
        end

        // Counters count rising edges of their selected input
        for (int i = 0; i < 2; i++) begin
            ccode = r.dev_sel[`DUS_DEV_CCODE_LSB + 4 * i +: 2];
            case (ccode)
                2'h0: csrc = (i == 0) ? (r.pg_st[0] == DUS_PG_GATE) :
                    !(&r.cnt[0]);
                2'h1: csrc = r.s2[0];
                2'h2: csrc = r.s2[1];
                default: csrc = r.stack_start;
            endcase
            next_r.cnt_sd[i] = csrc;
            if (r.dev_sel[`DUS_DEV_CEN + 4 * i] && csrc && !r.cnt_sd[i]) begin
                next_r.cnt[i] = 32'(r.cnt[i] + 32'h1);
            end
        end

        // Register writes; counter clears win over a count this cycle
        if (REG_WR) begin
            case (REG_ADDR)
                `DUS_OFF_ACQ: next_r.acq = REG_WDATA;
                `DUS_OFF_LED: next_r.led_sel = REG_WDATA;
                `DUS_OFF_PG1: next_r.pg1 = REG_WDATA;
                `DUS_OFF_PG2: next_r.pg2 = REG_WDATA;
                `DUS_OFF_EXT: next_r.ext = REG_WDATA;
                `DUS_OFF_DEV: begin
                    for (int i = 0; i < 2; i++) begin
                        if (REG_WDATA[`DUS_DEV_CRST + 4 * i]) begin
                            next_r.cnt[i] = '0;
                        end
                    end
                    if (REG_WDATA[`DUS_DEV_FRZ]) begin
                        // Frozen write touches only the enables
                        for (int i = 0; i < 2; i++) begin
                            next_r.dev_sel[`DUS_DEV_CEN + 4 * i] =
                                REG_WDATA[`DUS_DEV_CEN + 4 * i];
                        end
                    end else if (!REG_WDATA[`DUS_DEV_CRST] &&
                        !REG_WDATA[`DUS_DEV_CRST + 4]) begin
                        next_r.dev_sel = REG_WDATA;
                        next_r.dev_sel[`DUS_DEV_FRZ] = 1'b0;
                    end
                end
                default: ; // Counter values are read-only
            endcase
        end

        // Register reads answer one clock later; unmapped reads zero
        if (REG_RD) begin
            next_r.rvalid = 1'b1;
            case (REG_ADDR)
                `DUS_OFF_ACQ: next_r.rdata = r.acq;
                `DUS_OFF_LED: next_r.rdata = r.led_sel;
                `DUS_OFF_DEV: next_r.rdata = r.dev_sel;
                `DUS_OFF_PG1: next_r.rdata = r.pg1;
                `DUS_OFF_PG2: next_r.rdata = r.pg2;
                `DUS_OFF_CNT1: next_r.rdata = r.cnt[0];
                `DUS_OFF_CNT2: next_r.rdata = r.cnt[1];
                `DUS_OFF_EXT: next_r.rdata = r.ext;
                default: next_r.rdata = `DUS_RST_WORD;
            endcase
        end

        // Indicators 0..3 and NIM outputs 4..5
        for (int j = 0; j < 6; j++) begin
            if (j < 4) begin
                sel = r.led_sel[8 * j +: 5];
                spec = LED_STATUS[4 * j +: 4];
                shr = {r.s2[5], r.s2[4], r.s2[3], r.s2[2]};
            end else begin
                sel = r.dev_sel[8 * (j - 4) +: 5];
                spec = (j == 4) ?
                    {XFER_EVENT, r.s2[4], r.stack_start, r.busy} :
                    {XFER_BUFFER, r.s2[6], VME_CMD_EXEC, r.usb_trig};
                shr = {r.usb_trig, EVENT_END, r.pg_st[1] == DUS_PG_GATE,
                    r.pg_st[0] == DUS_PG_GATE};
            end
            v = (sel[2] ? shr[sel[1:0]] : spec[sel[1:0]]) ^ sel[`DUS_SEL_INV];
            // Clearing the latch bit drops the held level
            next_r.held[j] = sel[`DUS_SEL_LAT] && (r.held[j] || v);
            sig = v || (sel[`DUS_SEL_LAT] && r.held[j]);
            // Short pulses are collected so a tick never misses them
            if (r.tick) begin
                next_r.lout[j] = r.acc[j] || sig;
                next_r.acc[j] = 1'b0;
            end else begin
                next_r.acc[j] = r.acc[j] || sig;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Synchronous reset clears every field, generators to idle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign REG_RDATA = r.rdata;
    assign REG_RVALID = r.rvalid;
    assign STACK_START = r.stack_start;
    assign SCALER_STACK_START = r.sc_start;
    assign BUSY = r.busy;
    assign USB_TRIGGER = r.usb_trig;
    assign LED = r.lout[3:0];
    assign NIM_OUTPUT_ONE = r.lout[4];
    assign NIM_OUTPUT_TWO = r.lout[5];

endmodule
